// *** hw/vid_pkg.sv ***
/*
  vid_pkg: constants and types for the virtual-8086 interrupt dispatch sequencer.
  Assumes a 32-bit flat memory port on the core clock.
*/
package vid_pkg;
  // status word bit positions
  localparam int TF_BIT = 8;
  localparam int IF_BIT = 9;
  localparam int IO_PRIVILEGE_LEVEL_LO = 12;
  localparam int NT_BIT = 14;
  localparam int RF_BIT = 16;
  localparam int VM_BIT = 17;
  localparam logic [1:0] IO_PRIVILEGE_LEVEL_FULL = 2'h3;
  // task state segment offsets of the level-0 stack
  localparam logic [31:0] TSS_ESP0_OFS = 32'h0000_0004;
  localparam logic [31:0] TSS_SS0_OFS = 32'h0000_0008;
  // 8086 vector table sits at linear zero
  localparam logic [31:0] VEC_TABLE_BASE = 32'h0000_0000;
  localparam logic [31:0] SLOT32 = 32'h0000_0004;
  localparam logic [15:0] SLOT16 = 16'h0002;
  // last memory step of each sequence
  localparam logic [3:0] PM_LAST_ERR = 4'hB;
  localparam logic [3:0] PM_LAST = 4'hA;
  localparam logic [3:0] V86_LAST = 4'h3;
  localparam logic [3:0] IRPM_LAST = 4'h8;
  localparam logic [3:0] IRV86_LAST = 4'h2;
  typedef enum logic [2:0] {K_SWINT, K_EXT, K_DBG1, K_BKPT, K_INTERRUPT_RETURN} vid_kind_t;
  typedef enum logic [1:0] {M_PM, M_V86, M_IRPM, M_IRV86} vid_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_FINISH} vid_state_t;
  typedef struct packed {
    logic we;
    logic half;
    logic [31:0] addr;
    logic [31:0] wdata;
  } vid_mem_op_t;
  typedef struct packed {
    logic [15:0] es;
    logic [15:0] ds;
    logic [15:0] fs;
    logic [15:0] gs;
  } vid_seg_t;
endpackage

// *** hw/vid_dispatch.sv ***
/*
  vid_dispatch: picks the delivery path for software interrupts in virtual-8086
  mode, builds the handler frames and undoes them on interrupt return.
  Assumes the core holds its register inputs stable while busy is high and a
  memory that answers each held request with a one-cycle mem_ack.
*/
`timescale 1ns/100ps
module vid_dispatch (
  input logic clk_sys,
  input logic srst,
  input logic req_valid,
  input vid_pkg::vid_kind_t req_kind,
  input logic [7:0] req_vector,
  input logic err_valid,
  input logic [31:0] err_code,
  input logic long_mode,
  input logic virtual_mode_extensions_enable,
  input logic [255:0] redir_map,
  input logic gate_trap,
  input logic [15:0] gate_sel,
  input logic [31:0] gate_off,
  input logic [31:0] tss_base,
  input logic [31:0] psw_in,
  input logic [15:0] cs_in,
  input logic [31:0] eip_in,
  input logic [15:0] ss_in,
  input logic [31:0] esp_in,
  input vid_pkg::vid_seg_t seg_in,
  input logic mem_ack,
  input logic [31:0] mem_rdata,
  output logic mem_req_reg,
  output vid_pkg::vid_mem_op_t mem_op_reg,
  output logic busy_reg,
  output logic gp_fault_reg,
  output logic virt_int_reg,
  output logic not_taken_reg,
  output logic done_reg,
  output logic [31:0] res_psw_reg,
  output logic [15:0] res_cs_reg,
  output logic [31:0] res_eip_reg,
  output logic [15:0] res_ss_reg,
  output logic [31:0] res_esp_reg,
  output vid_pkg::vid_seg_t res_seg_reg
);
  vid_pkg::vid_state_t st_reg;
  vid_pkg::vid_mode_t mode_reg;
  logic [3:0] idx_reg;
  logic [31:0] sp_reg;
  logic [15:0] nss_reg;
  logic [31:0] psw_s, eip_s, esp_s, err_s, goff_s, tss_s;
  logic [15:0] cs_s, ss_s, gsel_s;
  logic [7:0] vec_s;
  logic errv_s, trap_s;
  vid_pkg::vid_seg_t seg_s;
  logic sw_take, ir_take, redir_bit, full_io_privilege_level;
  logic take_gp, take_virt, use_v86;
  logic [3:0] last_idx;
  vid_pkg::vid_mem_op_t op;
  logic [31:0] sp_next;
  logic [31:0] v86_base;

  // path selection; the map is only looked at when extensions are on
  assign full_io_privilege_level = psw_in[vid_pkg::IO_PRIVILEGE_LEVEL_LO +: 2] == vid_pkg::IO_PRIVILEGE_LEVEL_FULL;
  assign redir_bit = virtual_mode_extensions_enable & redir_map[req_vector];
  assign sw_take = req_valid & (req_kind == vid_pkg::K_SWINT) & psw_in[vid_pkg::VM_BIT]
                   & ~long_mode;
  assign ir_take = req_valid & (req_kind == vid_pkg::K_INTERRUPT_RETURN) & ~long_mode;
  assign take_gp = ~full_io_privilege_level & (~virtual_mode_extensions_enable | redir_bit);
  assign take_virt = ~full_io_privilege_level & virtual_mode_extensions_enable & ~redir_bit;
  assign use_v86 = full_io_privilege_level & virtual_mode_extensions_enable & ~redir_bit;
  assign v86_base = {12'h000, ss_s, 4'h0};

  // last memory step of the running sequence
  always_comb begin
    unique case (mode_reg)
      vid_pkg::M_PM: last_idx = errv_s ? vid_pkg::PM_LAST_ERR : vid_pkg::PM_LAST;
      vid_pkg::M_V86: last_idx = vid_pkg::V86_LAST;
      vid_pkg::M_IRPM: last_idx = vid_pkg::IRPM_LAST;
      vid_pkg::M_IRV86: last_idx = vid_pkg::IRV86_LAST;
    endcase
  end

  // memory step for the current index; new stack is taken as flat
  always_comb begin
    op = '0;
    sp_next = sp_reg;
    unique case (mode_reg)
      vid_pkg::M_PM: begin
        if (idx_reg == 4'h0) begin
          op.addr = tss_s + vid_pkg::TSS_ESP0_OFS;
        end else if (idx_reg == 4'h1) begin
          op.addr = tss_s + vid_pkg::TSS_SS0_OFS;
        end else begin
          sp_next = sp_reg - vid_pkg::SLOT32;
          op.we = 1'b1;
          op.addr = sp_next;
          unique case (idx_reg)
            4'h2: op.wdata = {16'h0000, seg_s.gs};
            4'h3: op.wdata = {16'h0000, seg_s.fs};
            4'h4: op.wdata = {16'h0000, seg_s.ds};
            4'h5: op.wdata = {16'h0000, seg_s.es};
            4'h6: op.wdata = {16'h0000, ss_s};
            4'h7: op.wdata = esp_s;
            4'h8: op.wdata = psw_s;
            4'h9: op.wdata = {16'h0000, cs_s};
            4'hA: op.wdata = eip_s;
            default: op.wdata = err_s;
          endcase
        end
      end
      vid_pkg::M_V86: begin
        if (idx_reg == 4'h3) begin
          op.addr = vid_pkg::VEC_TABLE_BASE + {22'h000000, vec_s, 2'b00};
        end else begin
          sp_next = {16'h0000, sp_reg[15:0] - vid_pkg::SLOT16};
          op.we = 1'b1;
          op.half = 1'b1;
          op.addr = v86_base + sp_next;
          unique case (idx_reg)
            4'h0: op.wdata = {16'h0000, psw_s[15:0]};
            4'h1: op.wdata = {16'h0000, cs_s};
            default: op.wdata = {16'h0000, eip_s[15:0]};
          endcase
        end
      end
      vid_pkg::M_IRPM: begin
        op.addr = sp_reg;
        sp_next = sp_reg + vid_pkg::SLOT32;
      end
      vid_pkg::M_IRV86: begin
        op.half = 1'b1;
        op.addr = v86_base + {16'h0000, sp_reg[15:0]};
        sp_next = {16'h0000, sp_reg[15:0] + vid_pkg::SLOT16};
      end
    endcase
  end

  // sequencer; requests arriving while busy are not looked at
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_reg <= vid_pkg::ST_IDLE;
      mode_reg <= vid_pkg::M_PM;
      idx_reg <= 4'h0;
      busy_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        vid_pkg::ST_IDLE: begin
          idx_reg <= 4'h0;
          if (sw_take && (full_io_privilege_level && !use_v86)) begin
            mode_reg <= vid_pkg::M_PM;
            st_reg <= vid_pkg::ST_ISSUE;
            busy_reg <= 1'b1;
          end else if (sw_take && use_v86) begin
            mode_reg <= vid_pkg::M_V86;
            st_reg <= vid_pkg::ST_ISSUE;
            busy_reg <= 1'b1;
          end else if (ir_take) begin
            mode_reg <= psw_in[vid_pkg::VM_BIT] ? vid_pkg::M_IRV86 : vid_pkg::M_IRPM;
            st_reg <= vid_pkg::ST_ISSUE;
            busy_reg <= 1'b1;
          end
        end
        vid_pkg::ST_ISSUE: st_reg <= vid_pkg::ST_WAIT;
        vid_pkg::ST_WAIT: begin
          if (mem_ack) begin
            idx_reg <= idx_reg + 4'h1;
            st_reg <= (idx_reg == last_idx) ? vid_pkg::ST_FINISH : vid_pkg::ST_ISSUE;
          end
        end
        vid_pkg::ST_FINISH: begin
          st_reg <= vid_pkg::ST_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  // memory port; the request holds until acknowledged
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem_req_reg <= 1'b0;
      mem_op_reg <= '0;
    end else if (st_reg == vid_pkg::ST_ISSUE) begin
      mem_req_reg <= 1'b1;
      mem_op_reg <= op;
    end else if (st_reg == vid_pkg::ST_WAIT && mem_ack) begin
      mem_req_reg <= 1'b0;
    end
  end

  // one-cycle outcome pulses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gp_fault_reg <= 1'b0;
      virt_int_reg <= 1'b0;
      not_taken_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      gp_fault_reg <= (st_reg == vid_pkg::ST_IDLE) && sw_take && take_gp;
      virt_int_reg <= (st_reg == vid_pkg::ST_IDLE) && sw_take && take_virt;
      not_taken_reg <= (st_reg == vid_pkg::ST_IDLE) && req_valid && !sw_take && !ir_take;
      done_reg <= st_reg == vid_pkg::ST_FINISH;
    end
  end

  // snapshot of the interrupted context at acceptance
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {psw_s, eip_s, esp_s, err_s, goff_s, tss_s} <= '0;
      {cs_s, ss_s, gsel_s, vec_s, errv_s, trap_s} <= '0;
      seg_s <= '0;
    end else if (st_reg == vid_pkg::ST_IDLE && (sw_take || ir_take)) begin
      {psw_s, eip_s, esp_s, err_s, goff_s, tss_s} <=
        {psw_in, eip_in, esp_in, err_code, gate_off, tss_base};
      {cs_s, ss_s, gsel_s, vec_s, errv_s, trap_s} <=
        {cs_in, ss_in, gate_sel, req_vector, err_valid, gate_trap};
      seg_s <= seg_in;
    end
  end

  // stack pointer walk; in the protected-mode path the first read loads the level-0 pointer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sp_reg <= '0;
      nss_reg <= '0;
    end else if (st_reg == vid_pkg::ST_IDLE) begin
      sp_reg <= esp_in;
    end else if (st_reg == vid_pkg::ST_WAIT && mem_ack) begin
      sp_reg <= (mode_reg == vid_pkg::M_PM && idx_reg == 4'h0) ? mem_rdata : sp_next;
      if (mode_reg == vid_pkg::M_PM && idx_reg == 4'h1) begin
        nss_reg <= mem_rdata[15:0];
      end
    end
  end

  // resulting architectural state, valid when done pulses
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      res_psw_reg <= '0;
      res_cs_reg <= '0;
      res_eip_reg <= '0;
      res_ss_reg <= '0;
      res_esp_reg <= '0;
      res_seg_reg <= '0;
    end else if (st_reg == vid_pkg::ST_WAIT && mem_ack) begin
      if (mode_reg == vid_pkg::M_V86 && idx_reg == 4'h3) begin
        res_eip_reg <= {16'h0000, mem_rdata[15:0]};
        res_cs_reg <= mem_rdata[31:16];
      end else if (mode_reg == vid_pkg::M_IRPM) begin
        unique case (idx_reg)
          4'h0: res_eip_reg <= mem_rdata;
          4'h1: res_cs_reg <= mem_rdata[15:0];
          4'h2: res_psw_reg <= mem_rdata;
          4'h3: res_esp_reg <= mem_rdata;
          4'h4: res_ss_reg <= mem_rdata[15:0];
          4'h5: res_seg_reg.es <= mem_rdata[15:0];
          4'h6: res_seg_reg.ds <= mem_rdata[15:0];
          4'h7: res_seg_reg.fs <= mem_rdata[15:0];
          default: res_seg_reg.gs <= mem_rdata[15:0];
        endcase
      end else if (mode_reg == vid_pkg::M_IRV86) begin
        unique case (idx_reg)
          4'h0: res_eip_reg <= {16'h0000, mem_rdata[15:0]};
          4'h1: res_cs_reg <= mem_rdata[15:0];
          default: res_psw_reg <= {psw_s[31:16], mem_rdata[15:0]};
        endcase
      end
    end else if (st_reg == vid_pkg::ST_FINISH) begin
      if (mode_reg == vid_pkg::M_PM) begin
        res_psw_reg <= psw_s;
        res_psw_reg[vid_pkg::TF_BIT] <= 1'b0;
        res_psw_reg[vid_pkg::NT_BIT] <= 1'b0;
        res_psw_reg[vid_pkg::RF_BIT] <= 1'b0;
        res_psw_reg[vid_pkg::VM_BIT] <= 1'b0;
        res_psw_reg[vid_pkg::IF_BIT] <= trap_s & psw_s[vid_pkg::IF_BIT];
        res_cs_reg <= gsel_s;
        res_eip_reg <= goff_s;
        res_ss_reg <= nss_reg;
        res_esp_reg <= sp_reg;
        res_seg_reg <= '0;
      end else if (mode_reg == vid_pkg::M_V86) begin
        res_psw_reg <= psw_s;
        res_psw_reg[vid_pkg::IF_BIT] <= 1'b0;
        res_psw_reg[vid_pkg::RF_BIT] <= 1'b0;
        res_ss_reg <= ss_s;
        res_esp_reg <= {esp_s[31:16], sp_reg[15:0]};
        res_seg_reg <= seg_s;
      end else if (mode_reg == vid_pkg::M_IRV86) begin
        res_ss_reg <= ss_s;
        res_esp_reg <= {esp_s[31:16], sp_reg[15:0]};
        res_seg_reg <= seg_s;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_idle_sw;
    st_reg == vid_pkg::ST_IDLE && sw_take;
  endsequence
  sequence s_pm_done;
    done_reg && mode_reg == vid_pkg::M_PM;
  endsequence

  a_gp_select: assert property (
    s_idle_sw ##0 take_gp |=> gp_fault_reg && !busy_reg)
    else $error("fault not raised");
  a_virt_select: assert property (
    s_idle_sw ##0 take_virt |=> virt_int_reg && !busy_reg ##1 !virt_int_reg)
    else $error("virtual interrupt not flagged");
  a_excluded_kind: assert property (
    st_reg == vid_pkg::ST_IDLE && req_valid && req_kind inside {vid_pkg::K_EXT,
      vid_pkg::K_DBG1, vid_pkg::K_BKPT} |=> not_taken_reg && !busy_reg)
    else $error("excluded interrupt was dispatched");
  a_long_blocked: assert property (
    st_reg == vid_pkg::ST_IDLE && req_valid && long_mode |=> not_taken_reg && !busy_reg)
    else $error("dispatch in long mode");
  a_v86_first_push: assert property (
    s_idle_sw ##0 use_v86 |=> mode_reg == vid_pkg::M_V86 ##1
      mem_req_reg && mem_op_reg.half && mem_op_reg.wdata[15:0] == $past(psw_in[15:0], 2))
    else $error("8086 frame does not start with status half");
  a_tss_first: assert property (
    $rose(mem_req_reg) && mode_reg == vid_pkg::M_PM && idx_reg == 4'h0 |->
      !mem_op_reg.we && mem_op_reg.addr == tss_s + vid_pkg::TSS_ESP0_OFS)
    else $error("stack fetch not first");
  a_seg_push: assert property (
    mem_req_reg && mode_reg == vid_pkg::M_PM && idx_reg == 4'h2 |->
      mem_op_reg.we && mem_op_reg.wdata == {16'h0000, seg_s.gs})
    else $error("wrong first selector push");
  a_pm_exit: assert property (
    s_pm_done |-> res_seg_reg == '0 && !res_psw_reg[vid_pkg::VM_BIT] &&
      !res_psw_reg[vid_pkg::TF_BIT] && !res_psw_reg[vid_pkg::NT_BIT] && res_cs_reg == gsel_s)
    else $error("protected entry state wrong");
  a_if_gate: assert property (
    s_pm_done |-> res_psw_reg[vid_pkg::IF_BIT] == (trap_s && psw_s[vid_pkg::IF_BIT]))
    else $error("enable bit mishandled");
  a_vec_addr: assert property (
    mem_req_reg && mode_reg == vid_pkg::M_V86 && idx_reg == 4'h3 |->
      !mem_op_reg.we && mem_op_reg.addr == {22'h000000, vec_s, 2'b00})
    else $error("vector table address wrong");
  a_v86_exit: assert property (
    done_reg && mode_reg == vid_pkg::M_V86 |-> !res_psw_reg[vid_pkg::IF_BIT] &&
      !res_psw_reg[vid_pkg::RF_BIT] && res_psw_reg[vid_pkg::VM_BIT] == psw_s[vid_pkg::VM_BIT])
    else $error("8086 entry flags wrong");
endmodule // vid_dispatch

// *** bench/vid_mem_model.sv ***
/*
  vid_mem_model: behavioural system memory behind the dispatch block, holding
  stacks, task state and the 8086 vector table.
  Assumes the requester holds mem_op_reg steady until the ack edge.
*/
`timescale 1ns/100ps
module vid_mem_model (
  input logic clk_sys,
  input logic mem_req_reg,
  input vid_pkg::vid_mem_op_t mem_op_reg,
  input logic [1:0] dly,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] store [logic [31:0]];
  logic [1:0] wait_reg = 2'h0;
  logic [31:0] word;
  initial mem_ack = 1'b0;
  initial mem_rdata = 32'h0;

  // preload from the bench
  function automatic void poke(input logic [31:0] a, input logic [31:0] d);
    store[a] = d;
  endfunction

  // one ack per held request after dly waits; idle data toggles so stale words never match
  always @(posedge clk_sys) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req_reg && !mem_ack) begin
      wait_reg <= wait_reg + 2'h1;
      if (wait_reg >= dly) begin
        wait_reg <= 2'h0;
        word = store.exists(mem_op_reg.addr) ? store[mem_op_reg.addr] : ~mem_op_reg.addr;
        if (mem_op_reg.we) store[mem_op_reg.addr] = mem_op_reg.wdata;
        if (mem_op_reg.half) word[31:16] = ~word[31:16]; // upper half inverted on 16-bit reads
        mem_ack <= 1'b1;
        mem_rdata <= word;
      end
    end
  end
endmodule // vid_mem_model

// *** bench/vid_dispatch_test.sv ***
/*
  vid_dispatch_test: self-checking bench for the virtual-8086 interrupt dispatch block.
  Assumes vid_mem_model as the memory and one request in flight at a time.
*/
`timescale 1ns/100ps
module vid_dispatch_test;
  typedef struct packed {
    vid_pkg::vid_kind_t kind;
    logic [7:0] vec;
    logic errv;
    logic [31:0] err;
    logic lm;
    logic ext;
    logic [255:0] map;
    logic trap;
    logic [15:0] gsel;
    logic [31:0] goff;
    logic [31:0] tbase;
    logic [31:0] psw;
    logic [15:0] cs;
    logic [31:0] pc;
    logic [15:0] ss;
    logic [31:0] sp;
    vid_pkg::vid_seg_t seg;
  } vid_drv_t;
  typedef struct packed {
    logic [195:0] val;
    logic [195:0] msk;
  } vid_exp_t;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] dly = 2'h0;
  vid_drv_t drv = '0;
  logic mem_ack, mem_req_reg, busy_reg, gp_fault_reg, virt_int_reg, not_taken_reg, done_reg;
  logic [31:0] mem_rdata, res_psw_reg, res_eip_reg, res_esp_reg;
  logic [15:0] res_cs_reg, res_ss_reg;
  vid_pkg::vid_mem_op_t mem_op_reg;
  vid_pkg::vid_seg_t res_seg_reg;
  vid_exp_t resq [$];
  vid_exp_t opq [$];
  vid_exp_t ew;
  integer seed = 65;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rv;

  vid_dispatch dut (.clk_sys(clk_sys), .srst(srst), .req_valid(req_valid),
    .req_kind(drv.kind), .req_vector(drv.vec), .err_valid(drv.errv), .err_code(drv.err),
    .long_mode(drv.lm), .virtual_mode_extensions_enable(drv.ext), .redir_map(drv.map),
    .gate_trap(drv.trap), .gate_sel(drv.gsel), .gate_off(drv.goff), .tss_base(drv.tbase),
    .psw_in(drv.psw), .cs_in(drv.cs), .eip_in(drv.pc), .ss_in(drv.ss), .esp_in(drv.sp),
    .seg_in(drv.seg), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req_reg(mem_req_reg),
    .mem_op_reg(mem_op_reg), .busy_reg(busy_reg), .gp_fault_reg(gp_fault_reg),
    .virt_int_reg(virt_int_reg), .not_taken_reg(not_taken_reg), .done_reg(done_reg),
    .res_psw_reg(res_psw_reg), .res_cs_reg(res_cs_reg), .res_eip_reg(res_eip_reg),
    .res_ss_reg(res_ss_reg), .res_esp_reg(res_esp_reg), .res_seg_reg(res_seg_reg));
  vid_mem_model mem (.clk_sys(clk_sys), .mem_req_reg(mem_req_reg), .mem_op_reg(mem_op_reg),
    .dly(dly), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // clock, 40 ns period
  initial forever #20 clk_sys = ~clk_sys;

  task automatic final_report();
    // a note left unanswered means a result never appeared
    if (resq.size() != 0 || opq.size() != 0) miscompares++;
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // masked compare; unknowns in the compared bits of the design value never match
  task automatic cmp(input logic [195:0] g, input logic [195:0] e, input logic [195:0] m);
    compares++;
    if (((g ^ e) & m) !== 196'h0) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g & m, e & m);
    end
  endtask

  // expected memory operations, in issue order
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic h);
    opq.push_back('{{130'h0, 1'b1, h, a, d}, {130'h0, 34'h3_FFFF_FFFF, {h ? 16'h0 : 16'hFFFF},
      16'hFFFF}});
  endtask
  task automatic rd(input logic [31:0] a, input logic h);
    opq.push_back('{{130'h0, 1'b0, h, a, 32'h0}, {130'h0, 34'h3_FFFF_FFFF, 32'h0}});
  endtask
  function automatic logic [31:0] lin(input logic [15:0] s, input logic [15:0] o);
    return {12'h0, s, 4'h0} + {16'h0, o};
  endfunction

  // one request: random state, expectations from the rules, then drive and drain
  task automatic go(input vid_pkg::vid_kind_t k, input logic vm, input logic [1:0] pl,
    input logic ext, input logic bt, input logic lm, input logic trap, input logic ev);
    logic [31:0] p, pc, sp, tb, rp;
    logic [31:0] w [10];
    logic [31:0] l [10];
    logic [15:0] cs, ss;
    logic [63:0] sg;
    logic [7:0] v;
    logic [255:0] map;
    vid_exp_t x;
    int n;
    p = $random(seed);
    pc = $random(seed);
    sp = $random(seed);
    tb = $random(seed);
    {cs, ss} = $random(seed);
    sg = {$random(seed), $random(seed)};
    map = {8{$random(seed)}};
    v = 8'($random(seed));
    for (int i = 0; i < 10; i++) w[i] = $random(seed);
    p[vid_pkg::VM_BIT] = vm;
    p[vid_pkg::IO_PRIVILEGE_LEVEL_LO +: 2] = pl;
    map[v] = bt;
    x = '{196'h0, {4'hF, 192'h0}};
    if (lm || (k != vid_pkg::K_SWINT && k != vid_pkg::K_INTERRUPT_RETURN) || (k == vid_pkg::K_SWINT && !vm)) begin
      x.val[195:192] = 4'h2;
    end else if (k == vid_pkg::K_SWINT && pl != vid_pkg::IO_PRIVILEGE_LEVEL_FULL) begin
      x.val[195:192] = (ext && !bt) ? 4'h4 : 4'h8;
    end else if (k == vid_pkg::K_SWINT && !(ext && !bt)) begin
      mem.poke(tb + vid_pkg::TSS_ESP0_OFS, w[0]);
      mem.poke(tb + vid_pkg::TSS_SS0_OFS, w[1]);
      rd(tb + vid_pkg::TSS_ESP0_OFS, 1'b0);
      rd(tb + vid_pkg::TSS_SS0_OFS, 1'b0);
      l = '{{16'h0, sg[15:0]}, {16'h0, sg[31:16]}, {16'h0, sg[47:32]}, {16'h0, sg[63:48]},
        {16'h0, ss}, sp, p, {16'h0, cs}, pc, w[5]};
      n = ev ? 10 : 9;
      for (int i = 0; i < n; i++) wr(w[0] - 32'(4 * (i + 1)), l[i], 1'b0);
      rp = p;
      rp[vid_pkg::TF_BIT] = 1'b0;
      rp[vid_pkg::NT_BIT] = 1'b0;
      rp[vid_pkg::RF_BIT] = 1'b0;
      rp[vid_pkg::VM_BIT] = 1'b0;
      if (!trap) rp[vid_pkg::IF_BIT] = 1'b0;
      x = '{{4'h1, rp, w[3][15:0], w[4], w[1][15:0], w[0] - 32'(4 * n), 64'h0}, '1};
    end else if (k == vid_pkg::K_SWINT) begin
      wr(lin(ss, sp[15:0] - 16'h2), {16'h0, p[15:0]}, 1'b1);
      wr(lin(ss, sp[15:0] - 16'h4), {16'h0, cs}, 1'b1);
      wr(lin(ss, sp[15:0] - 16'h6), {16'h0, pc[15:0]}, 1'b1);
      mem.poke({22'h0, v, 2'h0}, w[0]);
      rd({22'h0, v, 2'h0}, 1'b0);
      rp = p;
      rp[vid_pkg::IF_BIT] = 1'b0;
      rp[vid_pkg::RF_BIT] = 1'b0;
      x.val = {4'h1, rp, w[0][31:16], 16'h0, w[0][15:0], ss, 16'h0, sp[15:0] - 16'h6, sg};
      x.msk = {36'hF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 32'h0000_FFFF, 64'hFFFF_FFFF_FFFF_FFFF};
    end else if (!vm) begin
      for (int i = 0; i < 9; i++) begin
        mem.poke(sp + 32'(4 * i), w[i]);
        rd(sp + 32'(4 * i), 1'b0);
      end
      x = '{{4'h1, w[2], w[1][15:0], w[0], w[4][15:0], w[3], w[5][15:0], w[6][15:0],
        w[7][15:0], w[8][15:0]}, '1};
    end else begin
      for (int i = 0; i < 3; i++) begin
        mem.poke(lin(ss, sp[15:0] + 16'(2 * i)), w[i]);
        rd(lin(ss, sp[15:0] + 16'(2 * i)), 1'b1);
      end
      x.val = {4'h1, 16'h0, w[2][15:0], w[1][15:0], 16'h0, w[0][15:0], 16'h0, 96'h0};
      x.msk = {4'hF, 16'h0, 32'hFFFF_FFFF, 16'h0, 16'hFFFF, 112'h0};
    end
    resq.push_back(x);
    @(posedge clk_sys);
    drv <= {k, v, ev, w[5], lm, ext, map, trap, w[3][15:0], w[4], tb, p, cs, pc, ss, sp, sg};
    dly <= 2'($random(seed));
    req_valid <= 1'b1;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    // a stray request while busy must be ignored
    for (int i = 0; i < 500 && (resq.size() != 0 || opq.size() != 0); i++) begin
      @(posedge clk_sys);
      req_valid <= (i == 4) && (busy_reg === 1'b1);
    end
    req_valid <= 1'b0;
    @(posedge clk_sys);
  endtask

  // watcher: every outcome pulse and every acked memory op takes the oldest note
  always @(posedge clk_sys) begin
    if ((gp_fault_reg | virt_int_reg | not_taken_reg | done_reg) === 1'b1) begin
      if (resq.size() == 0) cmp('1, '0, '1);
      else begin
        ew = resq.pop_front();
        cmp({gp_fault_reg, virt_int_reg, not_taken_reg, done_reg, res_psw_reg, res_cs_reg,
          res_eip_reg, res_ss_reg, res_esp_reg, res_seg_reg}, ew.val, ew.msk);
      end
    end
    if ((mem_req_reg & mem_ack) === 1'b1) begin
      if (opq.size() == 0) cmp('1, '0, '1);
      else begin
        ew = opq.pop_front();
        cmp({130'h0, mem_op_reg}, ew.val, ew.msk);
      end
    end
  end

  // hang guard, well beyond the expected few hundred cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    for (int k = 1; k < 4; k++) go(vid_pkg::vid_kind_t'(k), 1, 3, 1, 0, 0, 0, 0);
    go(vid_pkg::K_SWINT, 0, 3, 1, 0, 0, 0, 0);
    go(vid_pkg::K_SWINT, 1, 3, 1, 0, 1, 0, 0);
    go(vid_pkg::K_INTERRUPT_RETURN, 0, 3, 1, 0, 1, 0, 0);
    for (int pl = 0; pl < 3; pl++) begin
      go(vid_pkg::K_SWINT, 1, 2'(pl), 0, 0, 0, 0, 0);
      go(vid_pkg::K_SWINT, 1, 2'(pl), 1, 1, 0, 0, 0);
      go(vid_pkg::K_SWINT, 1, 2'(pl), 1, 0, 0, 0, 0);
    end
    go(vid_pkg::K_SWINT, 1, 3, 0, 0, 0, 0, 1);
    go(vid_pkg::K_SWINT, 1, 3, 1, 1, 0, 1, 0);
    go(vid_pkg::K_SWINT, 1, 3, 1, 0, 0, 0, 0);
    go(vid_pkg::K_INTERRUPT_RETURN, 0, 0, 0, 0, 0, 0, 0);
    go(vid_pkg::K_INTERRUPT_RETURN, 1, 3, 0, 0, 0, 0, 0);
    repeat (24) begin
      rv = $random(seed);
      go(vid_pkg::vid_kind_t'(3'(rv % 5)), rv[5], rv[7:6], rv[8], rv[9], rv[10] & rv[11],
        rv[12], rv[13]);
    end
    final_report();
  end
endmodule // vid_dispatch_test
